// ### cra_chk.sv
// Port checker for the reset and addressing-mode core
`timescale 1ns/100ps
`default_nettype none
module cra_chk (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Board pins and memory data
  input wire logic system_reset_low_in,
  input wire logic ready_in,
  input wire logic overflow_set_input_n_in,
  input wire logic [7:0] data_in,
  // Interrupt request
  input wire logic int_req_in,
  input wire cra_pkg::cra_int_kind_t int_kind_in,
  // Watched outputs
  input wire cra_pkg::cra_bus_t bus_out,
  input wire logic int_ack_out,
  input wire cra_pkg::cra_result_t result_out,
  input wire cra_pkg::cra_flags_t flags_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic vfn = bus_out.vector_fetch_flag_n;
  // Ready guards: pins pass two flops, so a freeze lags the pin by two edges
  a_rst_seq:
    assert property ($rose(system_reset_low_in) ##0 (ready_in && system_reset_low_in)[*8]
      |=> bus_out.addr == 16'hfffc && !vfn ##1 bus_out.addr == 16'hfffd && !vfn ##1 vfn)
    else $error("reset sequence wrong");
  a_vec_done:
    assert property ($rose(vfn) && $past(ready_in, 4) && $past(system_reset_low_in, 3)
      |-> bus_out.sync && bus_out.addr == {$past(data_in), $past(data_in, 2)})
    else $error("vector not loaded");
  a_rst_flags:
    assert property ($past(!system_reset_low_in, 3) |-> flags_out.irq_mask && !flags_out.decimal)
    else $error("reset flags wrong");
  a_keep_ovf:
    assert property (flags_out.overflow && !system_reset_low_in |=> flags_out.overflow)
    else $error("overflow lost");
  a_int_vec:
    assert property (result_out.valid && int_req_in && $past(ready_in, 2)
      && $past(system_reset_low_in, 2) |=> int_ack_out && !vfn
      && bus_out.addr == ($past(int_kind_in) == cra_pkg::CRA_INT_NMI ? 16'hfffa : 16'hfffe))
    else $error("interrupt vector wrong");
  a_sync_next:
    assert property ($fell(result_out.valid) && !$past(int_req_in)
      && $past(system_reset_low_in, 3) |-> bus_out.sync && vfn)
    else $error("no fetch after result");
  a_one_pulse:
    assert property (result_out.valid && $past(ready_in) && $past(ready_in, 2)
      |=> !result_out.valid)
    else $error("result pulse long");
  a_stack_page:
    assert property (result_out.valid && result_out.mode == cra_pkg::CRA_AM_STACK
      |-> result_out.ea[15:8] == 8'h01)
    else $error("stack off page one");
  a_ovf_set:
    assert property ($fell(overflow_set_input_n_in) && ready_in ##1
      (!overflow_set_input_n_in && ready_in)[*2] |-> ##[0:3] flags_out.overflow)
    else $error("overflow not set");
  a_abs_addr:
    assert property ($rose(result_out.valid) && result_out.mode == cra_pkg::CRA_AM_ABS
      && $past(ready_in, 3) && $past(ready_in, 4)
      |-> result_out.ea == {$past(data_in), $past(data_in, 2)})
    else $error("absolute address wrong");
  c_int: cover property (int_ack_out);
  c_freeze: cover property (bus_out.sync && !ready_in);
  c_ind: cover property (result_out.valid && result_out.mode == cra_pkg::CRA_AM_ABS_X_IND);
endmodule
bind cra_core cra_chk u_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
  .system_reset_low_in(system_reset_low_in), .ready_in(ready_in),
  .overflow_set_input_n_in(overflow_set_input_n_in), .data_in(data_in),
  .int_req_in(int_req_in), .int_kind_in(int_kind_in), .bus_out(bus_out),
  .int_ack_out(int_ack_out), .result_out(result_out), .flags_out(flags_out));
`default_nettype wire

// ### cra_core.sv
// Reset sequence, vector fetch, opcode-fetch marker and address sequencing
`timescale 1ns/100ps
`default_nettype none
`include "cra_defines.svh"

// Notes on behaviour
// - Ready input ignored while reset is low
// - Reset touches only decimal and mask flags
// - Reset release starts seven-cycle start-up sequence
// - Program counter loaded from reset vector
// - Falling overflow-set input sets overflow flag
// - Sync marker high for whole opcode-fetch cycle
// - Ready low freezes state until high
// - Vector-pull output low while reading vectors
// - Break/IRQ, reset and NMI vector addresses
// - One flat 16-bit address space
// - Absolute address from operand bytes, low first
// - Jump via pointer at operand plus X
// - Absolute base plus X or Y, sixteen bits
// - Jump via pointer at operand address
// - Accumulator mode is one byte
// - Immediate operand is byte after opcode
// - Implied mode is opcode byte only
// - Taken branch adds displacement, else falls through
// - Stack addresses are page one plus pointer
// - Zero page: high byte forced zero
// - Zero page plus X gives pointer
module cra_core (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Control pins from the board
  input wire logic system_reset_low_in,
  input wire logic ready_in,
  input wire logic overflow_set_input_n_in,
  // Memory bus
  input wire logic [7:0] data_in,
  output cra_pkg::cra_bus_t bus_out,
  // Instruction decoder and register file
  input wire cra_pkg::cra_dec_t dec_in,
  input wire cra_pkg::cra_index_t index_in,
  // Interrupt sequencing
  input wire logic int_req_in,
  input wire cra_pkg::cra_int_kind_t int_kind_in,
  output logic int_ack_out,
  // Results
  output cra_pkg::cra_result_t result_out,
  output logic [15:0] pc_out,
  output cra_pkg::cra_flags_t flags_out
);

  typedef enum logic [3:0] {
    ST_RST_HOLD,
    ST_RST_SEQ,
    ST_VEC_LO,
    ST_VEC_HI,
    ST_FETCH,
    ST_OP1,
    ST_OP2,
    ST_PTR_LO,
    ST_PTR_HI,
    ST_DONE
  } cra_state_t;

  cra_state_t state_q;
  cra_state_t state_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [7:0] lo_q;
  logic [7:0] lo_d;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic [7:0] ptr_lo_q;
  logic [7:0] ptr_lo_d;
  cra_pkg::cra_mode_t mode_q;
  cra_pkg::cra_mode_t mode_d;
  logic cond_q;
  logic cond_d;
  logic [15:0] vec_q;
  logic [15:0] vec_d;
  logic [15:0] addr_d;
  logic ack_d;
  cra_pkg::cra_result_t res_d;
  logic sov_prev_q;

  logic [2:0] pins_s;
  logic rst_pin_s;
  logic rdy_s;
  logic sov_s;
  logic in_reset_w;
  logic stall_w;
  logic sov_fall_w;
  logic sync_d;
  logic vpull_n_d;
  logic [7:0] lo_src_w;
  logic [7:0] hi_src_w;
  logic [15:0] ea_w;
  logic [15:0] ptr_next_w;
  logic [15:0] pc_inc_w;
  logic [15:0] branch_w;
  logic [15:0] int_vec_w;
  logic [15:0] ptr_val_w;
  logic is_jump_w;
  logic is_one_byte_w;
  logic is_ptr_w;

  // Pins arrive unsynchronised
  cra_sync #(
    .WIDTH(3),
    .RST_VAL(`CRA_SYNC_RESET)
  ) u_pin_sync (
    .clk_in(mclk_in),
    .rst_in(sys_rst_in),
    .async_in({overflow_set_input_n_in, ready_in, system_reset_low_in}),
    .sync_out(pins_s)
  );

  assign rst_pin_s = pins_s[0];
  assign rdy_s = pins_s[1];
  assign sov_s = pins_s[2];

  // A short reset pulse may be missed by the synchroniser
  assign in_reset_w = ~rst_pin_s;
  assign stall_w = ~rdy_s & ~in_reset_w;
  assign sov_fall_w = sov_prev_q & ~sov_s;

  cra_ea_unit u_ea (
    .mode_in(mode_q),
    .operand_low_byte_in(lo_src_w),
    .operand_high_byte_in(hi_src_w),
    .index_in(index_in),
    .ea_out(ea_w),
    .ptr_next_out(ptr_next_w)
  );

  // Operand bytes are used in the same cycle they are read
  assign lo_src_w = (state_q == ST_OP1) ? data_in : lo_q;
  assign hi_src_w = (state_q == ST_OP2) ? data_in : hi_q;
  assign pc_inc_w = pc_q + 16'h0001;
  assign branch_w = pc_inc_w + {{8{data_in[7]}}, data_in};
  assign ptr_val_w = {data_in, ptr_lo_q};
  assign int_vec_w = (int_kind_in == cra_pkg::CRA_INT_NMI) ?
                     `CRA_VEC_NMI : `CRA_VEC_IRQ;
  assign is_jump_w = (mode_q == cra_pkg::CRA_AM_ABS_IND) ||
                     (mode_q == cra_pkg::CRA_AM_ABS_X_IND);
  assign is_one_byte_w = (dec_in.mode == cra_pkg::CRA_AM_ACC) ||
                         (dec_in.mode == cra_pkg::CRA_AM_IMPL) ||
                         (dec_in.mode == cra_pkg::CRA_AM_STACK);
  assign is_ptr_w = is_jump_w || (mode_q == cra_pkg::CRA_AM_ZP_X_IND);

  assign sync_d = (state_d == ST_FETCH);
  assign vpull_n_d = ~((state_d == ST_VEC_LO) || (state_d == ST_VEC_HI));

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pc_d = pc_q;
    lo_d = lo_q;
    hi_d = hi_q;
    ptr_lo_d = ptr_lo_q;
    mode_d = mode_q;
    cond_d = cond_q;
    vec_d = vec_q;
    addr_d = bus_out.addr;
    ack_d = int_ack_out;
    res_d = result_out;
    if (in_reset_w) begin
      state_d = ST_RST_HOLD;
      cnt_d = 3'h0;
      ack_d = 1'b0;
      res_d.valid = 1'b0;
    end else if (!stall_w) begin
      ack_d = 1'b0;
      res_d.valid = 1'b0;
      unique case (state_q)
        ST_RST_HOLD: begin
          state_d = ST_RST_SEQ;
          cnt_d = 3'h1;
        end
        ST_RST_SEQ: begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == `CRA_RST_DUMMY_LAST) begin
            state_d = ST_VEC_LO;
            vec_d = `CRA_VEC_RESET;
            addr_d = `CRA_VEC_RESET;
          end
        end
        ST_VEC_LO: begin
          pc_d[7:0] = data_in;
          addr_d = vec_q + 16'h0001;
          state_d = ST_VEC_HI;
        end
        ST_VEC_HI: begin
          pc_d[15:8] = data_in;
          addr_d = {data_in, pc_q[7:0]};
          state_d = ST_FETCH;
        end
        ST_FETCH: begin
          mode_d = dec_in.mode;
          cond_d = dec_in.cond_met;
          pc_d = pc_inc_w;
          addr_d = pc_inc_w;
          if (is_one_byte_w) begin
            state_d = ST_DONE;
            res_d.valid = 1'b1;
            res_d.mode = dec_in.mode;
            res_d.ea = (dec_in.mode == cra_pkg::CRA_AM_STACK) ?
                       {`CRA_STACK_PAGE, index_in.sp} : 16'h0000;
          end else begin
            state_d = ST_OP1;
          end
        end
        ST_OP1: begin
          lo_d = data_in;
          pc_d = pc_inc_w;
          addr_d = pc_inc_w;
          res_d.mode = mode_q;
          unique case (mode_q)
            cra_pkg::CRA_AM_IMM: begin
              state_d = ST_DONE;
              res_d.valid = 1'b1;
              res_d.ea = pc_q;
              res_d.operand = data_in;
            end
            cra_pkg::CRA_AM_REL: begin
              state_d = ST_DONE;
              res_d.valid = 1'b1;
              if (cond_q) begin
                pc_d = branch_w;
                addr_d = branch_w;
              end
              res_d.ea = cond_q ? branch_w : pc_inc_w;
            end
            cra_pkg::CRA_AM_ZP: begin
              state_d = ST_DONE;
              res_d.valid = 1'b1;
              res_d.ea = ea_w;
            end
            cra_pkg::CRA_AM_ZP_X_IND: begin
              state_d = ST_PTR_LO;
              addr_d = ea_w;
            end
            default: begin
              state_d = ST_OP2;
            end
          endcase
        end
        ST_OP2: begin
          hi_d = data_in;
          pc_d = pc_inc_w;
          addr_d = pc_inc_w;
          res_d.mode = mode_q;
          if (is_jump_w) begin
            state_d = ST_PTR_LO;
            addr_d = ea_w;
          end else begin
            state_d = ST_DONE;
            res_d.valid = 1'b1;
            res_d.ea = ea_w;
          end
        end
        ST_PTR_LO: begin
          ptr_lo_d = data_in;
          addr_d = ptr_next_w;
          state_d = is_ptr_w ? ST_PTR_HI : ST_DONE;
        end
        ST_PTR_HI: begin
          state_d = ST_DONE;
          res_d.valid = 1'b1;
          res_d.mode = mode_q;
          res_d.ea = ptr_val_w;
          if (is_jump_w) begin
            pc_d = ptr_val_w;
            addr_d = ptr_val_w;
          end
        end
        ST_DONE: begin
          if (int_req_in) begin
            state_d = ST_VEC_LO;
            ack_d = 1'b1;
            vec_d = int_vec_w;
            addr_d = int_vec_w;
          end else begin
            state_d = ST_FETCH;
            addr_d = pc_q;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= ST_RST_HOLD;
      cnt_q <= 3'h0;
      pc_q <= `CRA_PC_RESET;
      lo_q <= 8'h00;
      hi_q <= 8'h00;
      ptr_lo_q <= 8'h00;
      mode_q <= cra_pkg::CRA_AM_IMPL;
      cond_q <= 1'b0;
      vec_q <= `CRA_VEC_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pc_q <= pc_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      ptr_lo_q <= ptr_lo_d;
      mode_q <= mode_d;
      cond_q <= cond_d;
      vec_q <= vec_d;
    end
  end

  // Outputs are registered so the marker spans the whole cycle
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_out <= '{addr: `CRA_PC_RESET, sync: 1'b0, vector_fetch_flag_n: 1'b1};
      int_ack_out <= 1'b0;
      result_out <= '0;
      pc_out <= `CRA_PC_RESET;
    end else begin
      bus_out <= '{addr: addr_d, sync: sync_d, vector_fetch_flag_n: vpull_n_d};
      int_ack_out <= ack_d;
      result_out <= res_d;
      pc_out <= pc_d;
    end
  end

  // Only mask and decimal follow the reset pin; overflow keeps its value
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flags_out <= '{overflow: `CRA_FLAG_V_RESET, decimal: `CRA_FLAG_D_RESET,
                     irq_mask: `CRA_FLAG_I_RESET};
      sov_prev_q <= 1'b1;
    end else begin
      sov_prev_q <= sov_s;
      if (sov_fall_w) begin
        flags_out.overflow <= 1'b1;
      end
      if (in_reset_w) begin
        flags_out.decimal <= 1'b0;
        flags_out.irq_mask <= 1'b1;
      end else if (ack_d) begin
        flags_out.irq_mask <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ### cra_defines.svh
// Address constants and sequence counts for the reset and addressing-mode core
`ifndef CRA_DEFINES_SVH
`define CRA_DEFINES_SVH

`define CRA_VEC_NMI 16'hfffa
`define CRA_VEC_RESET 16'hfffc
`define CRA_VEC_IRQ 16'hfffe
`define CRA_STACK_PAGE 8'h01
`define CRA_ZERO_PAGE 8'h00
`define CRA_RST_SEQ_CYCLES 3'h7
`define CRA_RST_VEC_CYCLES 3'h2
`define CRA_RST_DUMMY_LAST (`CRA_RST_SEQ_CYCLES - `CRA_RST_VEC_CYCLES)
`define CRA_PC_RESET 16'h0000
`define CRA_FLAG_V_RESET 1'b0
`define CRA_FLAG_D_RESET 1'b0
`define CRA_FLAG_I_RESET 1'b1
`define CRA_SYNC_RESET 3'h6

`endif

// ### cra_ea_unit.sv
// Effective-address former for the direct and pointer addressing modes
`timescale 1ns/100ps
`default_nettype none
`include "cra_defines.svh"

module cra_ea_unit (
  // Operand bytes and mode
  input wire cra_pkg::cra_mode_t mode_in,
  input wire logic [7:0] operand_low_byte_in,
  input wire logic [7:0] operand_high_byte_in,
  input wire cra_pkg::cra_index_t index_in,
  // Address or pointer, and the pointer's second byte address
  output logic [15:0] ea_out,
  output logic [15:0] ptr_next_out
);

  logic [15:0] base_w;
  logic [7:0] zp_sum_w;
  logic [7:0] zp_next_w;

  assign base_w = {operand_high_byte_in, operand_low_byte_in};
  // Carry out of the low byte is dropped so the pointer stays on page zero
  assign zp_sum_w = operand_low_byte_in + index_in.x;
  assign zp_next_w = zp_sum_w + 8'h01;

  always_comb begin
    ea_out = 16'h0000;
    unique case (mode_in)
      cra_pkg::CRA_AM_ABS: ea_out = base_w;
      cra_pkg::CRA_AM_ABS_IND: ea_out = base_w;
      cra_pkg::CRA_AM_ABS_X: ea_out = base_w + {8'h00, index_in.x};
      cra_pkg::CRA_AM_ABS_Y: ea_out = base_w + {8'h00, index_in.y};
      cra_pkg::CRA_AM_ABS_X_IND: ea_out = base_w + {8'h00, index_in.x};
      cra_pkg::CRA_AM_ZP: ea_out = {`CRA_ZERO_PAGE, operand_low_byte_in};
      cra_pkg::CRA_AM_ZP_X_IND: ea_out = {`CRA_ZERO_PAGE, zp_sum_w};
      cra_pkg::CRA_AM_STACK: ea_out = {`CRA_STACK_PAGE, index_in.sp};
      default: ea_out = 16'h0000;
    endcase
  end

  // Whole 64 KiB wrap for absolute and absolute-plus-X pointers, page-zero wrap for zero-page plus X ones
  assign ptr_next_out = (mode_in == cra_pkg::CRA_AM_ZP_X_IND) ?
                        {`CRA_ZERO_PAGE, zp_next_w} : ea_out + 16'h0001;

endmodule

`default_nettype wire

// ### cra_mem.sv
// Asynchronous-read memory on the core's parallel bus
`timescale 1ns/100ps
`default_nettype none
module cra_mem (
  // Address from the core
  input wire logic [15:0] addr_in,
  // Read data back
  output logic [7:0] data_out
);
  logic [7:0] cells [65536];
  // One flat space for code, stack and vectors
  assign data_out = cells[addr_in];
endmodule
`default_nettype wire

// ### cra_pkg.sv
// Types shared by the reset and addressing-mode core
package cra_pkg;

  typedef enum logic [3:0] {
    CRA_AM_ABS,
    CRA_AM_ABS_X_IND,
    CRA_AM_ABS_X,
    CRA_AM_ABS_Y,
    CRA_AM_ABS_IND,
    CRA_AM_ACC,
    CRA_AM_IMM,
    CRA_AM_IMPL,
    CRA_AM_REL,
    CRA_AM_STACK,
    CRA_AM_ZP,
    CRA_AM_ZP_X_IND
  } cra_mode_t;

  typedef enum logic [1:0] {
    CRA_INT_BRK,
    CRA_INT_IRQ,
    CRA_INT_NMI
  } cra_int_kind_t;

  typedef struct packed {
    cra_mode_t mode;
    logic cond_met;
  } cra_dec_t;

  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] sp;
  } cra_index_t;

  typedef struct packed {
    logic [15:0] addr;
    logic sync;
    logic vector_fetch_flag_n;
  } cra_bus_t;

  typedef struct packed {
    logic overflow;
    logic decimal;
    logic irq_mask;
  } cra_flags_t;

  typedef struct packed {
    logic valid;
    cra_mode_t mode;
    logic [15:0] ea;
    logic [7:0] operand;
  } cra_result_t;

endpackage

// ### cra_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none

module cra_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pins in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ### testbench.sv
// Self-checking bench for the reset and addressing-mode core
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic mclk_in = 0;
  logic sys_rst_in = 1;
  logic rstn = 0;
  logic rdy = 0;
  logic ovn = 1;
  logic ireq = 0;
  logic ack;
  logic [15:0] hold;
  logic [15:0] pc;
  cra_pkg::cra_int_kind_t ikind = cra_pkg::CRA_INT_BRK;
  cra_pkg::cra_dec_t dec = '0;
  cra_pkg::cra_index_t idx = '0;
  cra_pkg::cra_bus_t bus;
  cra_pkg::cra_result_t res;
  cra_pkg::cra_flags_t flg;
  wire logic [7:0] data;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #2 mclk_in = ~mclk_in;
  cra_mem u_mem (.addr_in(bus.addr), .data_out(data));
  cra_core uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .system_reset_low_in(rstn),
    .ready_in(rdy), .overflow_set_input_n_in(ovn), .data_in(data), .bus_out(bus),
    .dec_in(dec), .index_in(idx), .int_req_in(ireq), .int_kind_in(ikind),
    .int_ack_out(ack), .result_out(res), .pc_out(pc), .flags_out(flg));
  task automatic wrap_up();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  function automatic logic [15:0] w(input logic [15:0] a);
    return {u_mem.cells[a + 16'h1], u_mem.cells[a]};
  endfunction
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic pin_reset();
    rstn = 0;
    rdy = 0;  // Ready low must not stall the hold
    tick(5);
    chk(flg.irq_mask, 1'b1);
    chk(flg.decimal, 1'b0);
    rstn = 1;
    rdy = 1;
    tick(7);
    chk(bus.vector_fetch_flag_n, 1'b1);
    tick();
    chk(bus.addr, 16'hfffc);
    chk(bus.vector_fetch_flag_n, 1'b0);
    tick();
    chk(bus.addr, 16'hfffd);
    tick();
    chk(bus.addr, w(16'hfffc));
    chk(pc, w(16'hfffc));
    chk(bus.sync, 1'b1);
  endtask
  // Model of one instruction from its fetch cycle, optionally ending in an interrupt
  task automatic run(input cra_pkg::cra_mode_t md, input logic c, input logic irq,
    input cra_pkg::cra_int_kind_t k);
    logic [15:0] p, q, e, np, v;
    logic [7:0] b1, z;
    int i;
    p = bus.addr;
    idx = {8'($urandom), 8'($urandom), 8'($urandom)};
    dec = '{mode: md, cond_met: c};
    b1 = u_mem.cells[p + 16'h1];
    q = {u_mem.cells[p + 16'h2], b1};
    z = b1 + idx.x;
    e = 16'h0000;
    np = p + 16'h2;
    case (md)
      cra_pkg::CRA_AM_ACC, cra_pkg::CRA_AM_IMPL: np = p + 16'h1;
      cra_pkg::CRA_AM_STACK: begin
        e = {8'h01, idx.sp};
        np = p + 16'h1;
      end
      cra_pkg::CRA_AM_IMM: e = p + 16'h1;
      cra_pkg::CRA_AM_REL: np = c ? np + {{8{b1[7]}}, b1} : np;
      cra_pkg::CRA_AM_ZP: e = {8'h00, b1};
      cra_pkg::CRA_AM_ZP_X_IND: begin
        e = {u_mem.cells[{8'h00, z + 8'h1}], u_mem.cells[{8'h00, z}]};
      end
      cra_pkg::CRA_AM_ABS_IND: e = w(q);
      cra_pkg::CRA_AM_ABS_X_IND: e = w(q + {8'h00, idx.x});
      cra_pkg::CRA_AM_ABS_X: e = q + {8'h00, idx.x};
      cra_pkg::CRA_AM_ABS_Y: e = q + {8'h00, idx.y};
      default: e = q;
    endcase
    if (md inside {cra_pkg::CRA_AM_ABS, cra_pkg::CRA_AM_ABS_X, cra_pkg::CRA_AM_ABS_Y})
      np = p + 16'h3;
    if (md inside {cra_pkg::CRA_AM_ABS_IND, cra_pkg::CRA_AM_ABS_X_IND}) np = e;
    i = 0;
    while (res.valid !== 1'b1 && i < 12) begin
      tick();
      i++;
    end
    chk(res.valid, 1'b1);
    chk(res.mode, md);
    chk(res.ea, md == cra_pkg::CRA_AM_REL ? np : e);
    if (md == cra_pkg::CRA_AM_IMM) chk(res.operand, b1);
    ireq = irq;
    ikind = k;
    tick();
    if (irq) begin
      v = k == cra_pkg::CRA_INT_NMI ? 16'hfffa : 16'hfffe;
      chk(ack, 1'b1);
      chk(bus.addr, v);
      chk(bus.vector_fetch_flag_n, 1'b0);
      ireq = 0;
      tick();
      chk(bus.addr, v + 16'h1);
      tick();
      np = w(v);
      chk(flg.irq_mask, 1'b1);
    end
    chk(bus.sync, 1'b1);
    chk(bus.addr, np);
    chk(pc, np);
    chk(bus.vector_fetch_flag_n, 1'b1);
  endtask
  initial begin
    void'($urandom(66));
    for (int a = 0; a < 65536; a++) u_mem.cells[a] = 8'($urandom);
    repeat (4) @(posedge mclk_in);
    #1;
    sys_rst_in = 0;
    // Pin still held in reset, so the core cannot run off before its first fetch
    rdy = 1;
    chk(flg.overflow, 1'b0);
    ovn = 0;
    tick(6);
    chk(flg.overflow, 1'b1);
    ovn = 1;
    pin_reset();
    for (int n = 0; n < 40; n++)
      run(cra_pkg::cra_mode_t'(n < 12 ? n : $urandom_range(11)), 1'($urandom), 1'b0, ikind);
    for (int k = 0; k < 3; k++) run(cra_pkg::CRA_AM_ACC, 1'b0, 1'b1, cra_pkg::cra_int_kind_t'(k));
    // Two-cycle loop puts the freeze on a fetch cycle, as stepping logic would
    rdy = 0;
    tick(3);
    hold = bus.addr;
    tick(4);
    chk(bus.sync, 1'b1);
    chk(bus.addr, hold);
    chk(res.valid, 1'b0);
    rdy = 1;
    tick(2);
    run(cra_pkg::CRA_AM_IMM, 1'b0, 1'b0, ikind);
    pin_reset();
    chk(flg.overflow, 1'b1);
    run(cra_pkg::CRA_AM_ABS, 1'b0, 1'b0, ikind);
    wrap_up();
  end
endmodule
`default_nettype wire
